// ===== include/scs_consts.vh
// constants for the serial interface configuration and status register slice
`ifndef SCS_CONSTS_VH
`define SCS_CONSTS_VH

`define SCS_CFG_ADDR 8'ha1
`define SCS_CFG_RESET 8'h07
`define SCS_BIT_BUSY 7
`define SCS_BIT_MASTER 6
`define SCS_BIT_CPHA 5
`define SCS_BIT_CPOL 4
`define SCS_BIT_SELECTED 3
`define SCS_BIT_RAW_SEL 2
`define SCS_BIT_SHIFT_EMPTY 1
`define SCS_BIT_RX_EMPTY 0
`define SCS_BYTE_LAST 3'h7
`define SCS_HALF_BIT_DEFAULT 2
`define SCS_FIFO_DEPTH_DEFAULT 16
`define SCS_FIFO_AW_DEFAULT 4
// synchroniser reset: select high, clock at its reset idle (low), data low, master-in high
`define SCS_SYNC_RESET 4'h9

`endif

// ===== rtl/scs_sync.v
// three-stage pin synchroniser, output changes only when stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module scs_sync #(
  parameter WIDTH = 4,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b1}}
) (
  input wire clock_in, // core clock
  input wire rst_in, // async reset, active high
  input wire [WIDTH-1:0] async_in, // pins from outside the clock domain
  output wire [WIDTH-1:0] stage2_out, // second stage, undebounced level
  output reg [WIDTH-1:0] stable_out // level once stages agree
);
  reg [WIDTH-1:0] s1;
  reg [WIDTH-1:0] s2;
  reg [WIDTH-1:0] s3;

  assign stage2_out = s2;

  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      s1 <= RESET_VAL;
      s2 <= RESET_VAL;
      s3 <= RESET_VAL;
      stable_out <= RESET_VAL;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      // a bit where the stages disagree keeps its old value
      stable_out <= (s3 & ~(s2 ^ s3)) | (stable_out & (s2 ^ s3));
    end
  end
endmodule // scs_sync
`default_nettype wire

// ===== rtl/scs_fifo.v
// receive byte fifo with a registered output stage
`timescale 1ns/10ps
`default_nettype none
module scs_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clock_in, // core clock
  input wire rst_in, // async reset, active high
  input wire in_valid_in, // write request
  output wire in_ready_in_out, // space available
  input wire [WIDTH-1:0] in_data_in, // write data
  output reg out_valid_out, // output word valid
  input wire out_ready_in, // consumer takes word
  output reg [WIDTH-1:0] out_data_out, // output word
  output wire empty_out // nothing stored and nothing presented
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  assign in_ready_in_out = (count != DEPTH[AW:0]);
  assign empty_out = (count == {(AW+1){1'b0}}) && !out_valid_out;
  assign push = in_valid_in && in_ready_in_out;
  assign pop = (count != {(AW+1){1'b0}}) && (!out_valid_out || out_ready_in);

  always @(posedge clock_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      out_valid_out <= 1'b0;
      out_data_out <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
        out_data_out <= mem[rd_ptr];
        out_valid_out <= 1'b1;
      end else if (out_ready_in) begin
        out_valid_out <= 1'b0;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // scs_fifo
`default_nettype wire

// ===== rtl/scs_config_status.v
// serial interface configuration/status register with a minimal shift engine around it
// What this block does
// - busy flag high during any transfer
// - master select bit: 0 slave, 1 master
// - phase bit picks first or second edge
// - polarity bit sets serial clock idle level
// - selected flag is filtered inverse of select
// - raw select bit shows unfiltered pin level
// - slave shift empty sets when nothing pending
// - shift empty clears on load or clock edge
// - master mode: shift empty reads one
// - slave receive empty tracks unread received bytes
// - master mode: receive empty reads one
// - slave samples data mid bit
// - master samples one cycle before bit end
// - phase and polarity change only while disabled
`timescale 1ns/10ps
`default_nettype none
`include "scs_consts.vh"
module scs_config_status #(
  parameter HALF_BIT = `SCS_HALF_BIT_DEFAULT,
  parameter FIFO_DEPTH = `SCS_FIFO_DEPTH_DEFAULT,
  parameter FIFO_AW = `SCS_FIFO_AW_DEFAULT
) (
  input wire clock_in, // core clock, 25 mhz
  input wire rst_in, // async reset, active high
  input wire [7:0] sfr_addr_in, // special function register address
  input wire sfr_wr_in, // write strobe, one cycle
  input wire sfr_rd_in, // read strobe, one cycle
  input wire [7:0] sfr_wdata_in, // write data
  output reg [7:0] sfr_rdata_out, // read data, valid cycle after strobe
  input wire interface_enable_in, // interface enable from control register
  input wire tx_valid_in, // transmit byte offered
  input wire [7:0] tx_data_in, // transmit byte
  output reg tx_ready_out, // transmit buffer free
  output wire rx_valid_out, // received byte available
  output wire [7:0] rx_data_out, // received byte
  input wire rx_ready_in, // received byte taken
  input wire slave_select_in, // select pin, active low
  input wire sck_in, // serial clock pin level
  input wire mosi_in, // master-out pin level
  input wire miso_in, // master-in pin level
  output reg sck_out, // serial clock drive
  output reg sck_oe_out, // serial clock enable
  output reg mosi_out, // master-out drive
  output reg mosi_oe_out, // master-out enable
  output reg miso_out, // master-in drive
  output reg miso_oe_out // master-in enable
);
  localparam ST_IDLE = 2'b01;
  localparam ST_XFER = 2'b10;
  localparam integer LAST_CNT = 2 * HALF_BIT - 1;
  localparam integer SAMPLE_CNT = 2 * HALF_BIT - 2;

  // software visible mode bits
  reg master_sel;
  reg cpha_reg;
  reg cpol_reg;
  // copies the engine uses, refreshed only while disabled
  reg cpha_act;
  reg cpol_act;
  // status
  reg busy;
  reg shift_empty;
  reg rx_empty;
  // transmit buffer and shift registers
  reg [7:0] tx_buf;
  reg tx_full;
  reg [7:0] sh_tx;
  reg [7:0] sh_rx;
  reg sh_loaded;
  reg [2:0] bitcnt;
  reg [7:0] phase_cnt;
  reg [1:0] state;
  reg sck_prev;
  // receive push toward the fifo
  reg push_valid;
  reg [7:0] push_data;

  wire [3:0] pins_raw;
  wire [3:0] pins_st;
  wire nss_raw;
  wire nss_st;
  wire sck_st;
  wire mosi_st;
  wire miso_st;
  wire fifo_in_ready;
  wire fifo_empty;
  wire cfg_hit;
  wire slave_on;
  wire selected;
  wire sck_edge;
  wire leading;
  wire sample_edge;
  wire shift_edge;
  wire tx_take;
  wire master_start;
  wire slave_load;
  wire first_half;
  reg next_tx_full;
  reg next_shift_empty;

  scs_sync #(
    .WIDTH(4),
    .RESET_VAL(`SCS_SYNC_RESET)
  ) u_sync (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .async_in({slave_select_in, sck_in, mosi_in, miso_in}),
    .stage2_out(pins_raw),
    .stable_out(pins_st)
  );

  scs_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_rx_fifo (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .in_valid_in(push_valid),
    .in_ready_in_out(fifo_in_ready),
    .in_data_in(push_data),
    .out_valid_out(rx_valid_out),
    .out_ready_in(rx_ready_in),
    .out_data_out(rx_data_out),
    .empty_out(fifo_empty)
  );

  assign nss_raw = pins_raw[3];
  assign nss_st = pins_st[3];
  assign sck_st = pins_st[2];
  assign mosi_st = pins_st[1];
  assign miso_st = pins_st[0];

  assign cfg_hit = (sfr_addr_in == `SCS_CFG_ADDR);
  assign slave_on = interface_enable_in && !master_sel;
  assign selected = slave_on && !nss_st;
  assign sck_edge = sck_st ^ sck_prev;
  // leading edge leaves the idle level
  assign leading = sck_edge && (sck_st != cpol_act);
  assign sample_edge = cpha_act ? (sck_edge && !leading) : leading;
  assign shift_edge = cpha_act ? leading : (sck_edge && !leading);
  assign tx_take = tx_valid_in && tx_ready_out && !tx_full;
  // master holds off while the fifo is full; the check does not count a push still pending from the last byte
  assign master_start = (state == ST_IDLE) && interface_enable_in && master_sel
                        && tx_full && fifo_in_ready;
  assign slave_load = slave_on && tx_full && !sh_loaded && (bitcnt == 3'h0);
  // a bit is two halves of HALF_BIT core clocks each
  assign first_half = (phase_cnt < HALF_BIT[7:0]);

  always @* begin
    next_tx_full = tx_full;
    if (tx_take) begin
      next_tx_full = 1'b1;
    end else if (master_start || slave_load) begin
      next_tx_full = 1'b0;
    end
  end

  always @* begin
    next_shift_empty = shift_empty;
    if (master_sel) begin
      next_shift_empty = 1'b1;
    end else if (slave_load || (selected && sck_edge)) begin
      next_shift_empty = 1'b0;
    end else if (bitcnt == 3'h0 && !sh_loaded && !tx_full && !push_valid) begin
      next_shift_empty = 1'b1;
    end
  end

  // register access
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      master_sel <= 1'b0;
      cpha_reg <= 1'b0;
      cpol_reg <= 1'b0;
      sfr_rdata_out <= `SCS_CFG_RESET;
    end else begin
      if (sfr_wr_in && cfg_hit) begin
        master_sel <= sfr_wdata_in[`SCS_BIT_MASTER];
        cpha_reg <= sfr_wdata_in[`SCS_BIT_CPHA];
        cpol_reg <= sfr_wdata_in[`SCS_BIT_CPOL];
      end
      if (sfr_rd_in && cfg_hit) begin
        sfr_rdata_out[`SCS_BIT_BUSY] <= busy;
        sfr_rdata_out[`SCS_BIT_MASTER] <= master_sel;
        sfr_rdata_out[`SCS_BIT_CPHA] <= cpha_reg;
        sfr_rdata_out[`SCS_BIT_CPOL] <= cpol_reg;
        sfr_rdata_out[`SCS_BIT_SELECTED] <= !nss_st;
        // second stage only: no agreement filter on this bit
        sfr_rdata_out[`SCS_BIT_RAW_SEL] <= nss_raw;
        // the registered flags trail a mode write by one cycle, so the mode bit overrides
        sfr_rdata_out[`SCS_BIT_SHIFT_EMPTY] <= shift_empty || master_sel;
        sfr_rdata_out[`SCS_BIT_RX_EMPTY] <= rx_empty || master_sel;
      end else if (sfr_rd_in) begin
        sfr_rdata_out <= 8'h00;
      end
    end
  end

  // status flags and transmit buffer
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cpha_act <= 1'b0;
      cpol_act <= 1'b0;
      shift_empty <= 1'b1;
      rx_empty <= 1'b1;
      tx_full <= 1'b0;
      tx_buf <= 8'h00;
      tx_ready_out <= 1'b0;
      // same level as the synchroniser's clock stage, so reset makes no false edge
      sck_prev <= 1'b0;
    end else begin
      // a change while running would tear the current byte
      if (!interface_enable_in) begin
        cpha_act <= cpha_reg;
        cpol_act <= cpol_reg;
      end
      shift_empty <= next_shift_empty;
      rx_empty <= master_sel ? 1'b1 : (fifo_empty && !push_valid);
      if (tx_take) begin
        tx_buf <= tx_data_in;
      end
      tx_full <= next_tx_full;
      tx_ready_out <= !next_tx_full;
      sck_prev <= sck_st;
    end
  end

  // shift engine, master and slave
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state <= ST_IDLE;
      busy <= 1'b0;
      sh_tx <= 8'h00;
      sh_rx <= 8'h00;
      sh_loaded <= 1'b0;
      bitcnt <= 3'h0;
      phase_cnt <= 8'h00;
      push_valid <= 1'b0;
      push_data <= 8'h00;
      sck_out <= 1'b0;
      sck_oe_out <= 1'b0;
      mosi_out <= 1'b0;
      mosi_oe_out <= 1'b0;
      miso_out <= 1'b0;
      miso_oe_out <= 1'b0;
    end else begin
      push_valid <= 1'b0;
      sck_oe_out <= interface_enable_in && master_sel;
      mosi_oe_out <= interface_enable_in && master_sel;
      miso_oe_out <= selected;
      if (!interface_enable_in) begin
        state <= ST_IDLE;
        busy <= 1'b0;
        bitcnt <= 3'h0;
        sh_loaded <= 1'b0;
        sck_out <= cpol_reg;
      end else if (master_sel) begin
        case (state)
          ST_IDLE: begin
            sck_out <= cpol_act;
            if (master_start) begin
              state <= ST_XFER;
              busy <= 1'b1;
              sh_tx <= tx_buf;
              mosi_out <= tx_buf[7];
              bitcnt <= 3'h0;
              phase_cnt <= 8'h00;
            end
          end
          ST_XFER: begin
            // phase 0 toggles in mid bit, phase 1 at bit start
            sck_out <= cpol_act ^ (cpha_act ? first_half : !first_half);
            if (phase_cnt == SAMPLE_CNT[7:0]) begin
              sh_rx <= {sh_rx[6:0], miso_st};
            end
            if (phase_cnt == LAST_CNT[7:0]) begin
              phase_cnt <= 8'h00;
              if (bitcnt == `SCS_BYTE_LAST) begin
                state <= ST_IDLE;
                busy <= 1'b0;
                sck_out <= cpol_act;
                bitcnt <= 3'h0;
                push_valid <= 1'b1;
                push_data <= sh_rx;
              end else begin
                bitcnt <= bitcnt + 3'h1;
                mosi_out <= sh_tx[6];
                sh_tx <= {sh_tx[6:0], 1'b0};
              end
            end else begin
              phase_cnt <= phase_cnt + 8'h01;
            end
          end
          default: begin
            state <= ST_IDLE;
            busy <= 1'b0;
          end
        endcase
      end else begin
        state <= ST_IDLE;
        if (!selected) begin
          // deselect restarts the byte
          bitcnt <= 3'h0;
          busy <= 1'b0;
        end else begin
          if (sample_edge) begin
            // the sampling edge sits mid bit for both phases
            sh_rx <= {sh_rx[6:0], mosi_st};
            if (bitcnt == `SCS_BYTE_LAST) begin
              bitcnt <= 3'h0;
              busy <= 1'b0;
              sh_loaded <= 1'b0;
              // slave cannot stall the master: a full fifo drops the byte
              push_valid <= fifo_in_ready;
              push_data <= {sh_rx[6:0], mosi_st};
            end else begin
              bitcnt <= bitcnt + 3'h1;
              busy <= 1'b1;
            end
          end
          if (shift_edge && bitcnt != 3'h0) begin
            miso_out <= sh_tx[6];
            sh_tx <= {sh_tx[6:0], 1'b0};
          end
        end
        if (slave_load && !(selected && sample_edge)) begin
          sh_tx <= tx_buf;
          miso_out <= tx_buf[7];
          sh_loaded <= 1'b1;
        end
      end
    end
  end
endmodule // scs_config_status
`default_nettype wire

// ===== verification/scs_checker.sv
// concurrent checks on the configuration and status register ports
`timescale 1ns/10ps
`default_nettype none
`include "scs_consts.vh"
module scs_checker (
  input wire logic clock_in, // core clock
  input wire logic rst_in, // async reset
  input wire logic [7:0] sfr_addr_in, // address
  input wire logic sfr_wr_in, // write strobe
  input wire logic sfr_rd_in, // read strobe
  input wire logic [7:0] sfr_wdata_in, // write data
  input wire logic [7:0] sfr_rdata_out, // read data
  input wire logic interface_enable_in, // enable
  input wire logic rx_valid_out, // rx word
  input wire logic rx_ready_in, // rx take
  input wire logic slave_select_in, // select pin
  input wire logic sck_out, // clock drive
  input wire logic sck_oe_out // clock enable
);
  logic [2:0] cfg; // mode bits as last written
  wire rd_hit = sfr_rd_in && (sfr_addr_in == `SCS_CFG_ADDR);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) cfg <= 3'h0;
    else if (sfr_wr_in && sfr_addr_in == `SCS_CFG_ADDR) cfg <= sfr_wdata_in[6:4];
  end
  a_mode_readback:
    assert property (rd_hit |=> sfr_rdata_out[6:4] == $past(cfg))
    else $error("mode bits read back wrong");
  a_master_flags:
    assert property (rd_hit && cfg[2] |=> sfr_rdata_out[1:0] == 2'h3)
    else $error("master empty flags not set");
  a_unmapped_zero:
    assert property (sfr_rd_in && !rd_hit |=> sfr_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_holds:
    assert property (!sfr_rd_in |=> $stable(sfr_rdata_out))
    else $error("read data moved without read");
  a_select_low:
    assert property ((!slave_select_in)[*8] ##0 rd_hit |=> sfr_rdata_out[3:2] == 2'h2)
    else $error("select low not reported");
  a_select_high:
    assert property (slave_select_in[*8] ##0 rd_hit |=> sfr_rdata_out[3:2] == 2'h1)
    else $error("select high not reported");
  a_sck_idle:
    assert property ((!interface_enable_in && $stable(cfg))[*6] |-> sck_out == cfg[0])
    else $error("clock not at idle level");
  a_sck_master:
    assert property (sck_oe_out |-> cfg[2] || $past(cfg[2]))
    else $error("clock driven in slave mode");
  a_rx_flag:
    assert property (rd_hit && !cfg[2] && rx_valid_out |=> !sfr_rdata_out[0])
    else $error("receive empty set with byte pending");
  a_rx_hold:
    assert property (rx_valid_out && !rx_ready_in |=> rx_valid_out)
    else $error("rx word dropped before taken");
endmodule // scs_checker
`default_nettype wire

// ===== verification/scs_far_end.sv
// far-side model: external master for slave runs, external slave for master runs
`timescale 1ns/10ps
`default_nettype none
module scs_far_end (
  input wire logic sck_l_in, // clock line
  input wire logic mosi_l_in, // master-out line
  input wire logic miso_l_in, // master-in line
  output logic sck_out, // clock as master
  output logic mosi_out, // data as master
  output logic miso_out, // data as slave
  output logic nss_out // select, active low
);
  logic [7:0] cap = 8'h00; // last byte seen
  logic [7:0] rep = 8'h00; // reply shifter
  logic skip = 1'b0; // phase one: first leading edge keeps the preloaded bit
  initial begin
    sck_out = 1'b0;
    mosi_out = 1'b0;
    miso_out = 1'b1;
    nss_out = 1'b1;
  end
  // slave role, modes 0 and 3: capture on rise, shift on fall; junk follows the byte
  always @(posedge sck_l_in) if (nss_out) cap <= {cap[6:0], mosi_l_in};
  always @(negedge sck_l_in) if (nss_out) begin
    if (skip) begin
      skip = 1'b0;
    end else begin
      rep = {rep[6:0], ~rep[7]};
      miso_out = rep[7];
    end
  end
  task arm(input logic [7:0] b, input logic p);
    rep = b;
    miso_out = b[7];
    skip = p;
  endtask
  // master role, mode 0; clock stands low outside the frame
  task xfer(input logic [7:0] b);
    nss_out = 1'b0;
    #200;
    for (int i = 7; i >= 0; i--) begin
      mosi_out = b[i];
      #160 sck_out = 1'b1;
      // late in the high phase: the slave answers several core clocks after the fall
      #159 cap = {cap[6:0], miso_l_in};
      #1 sck_out = 1'b0;
    end
    #200 nss_out = 1'b1;
    mosi_out = ~mosi_out;
  endtask
endmodule // scs_far_end
`default_nettype wire

// ===== verification/tb.sv
// testbench for the configuration and status register slice
`timescale 1ns/10ps
`default_nettype none
`include "scs_consts.vh"
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin bad_count++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module tb;
  logic clk = 0, rst = 1, rd = 0, wr = 0, en = 0, txv = 0, rxr = 0;
  logic [7:0] adr = 0, wd = 0, txd = 0, lf = 8'h1b, d, m, t;
  int bad_count = 0, checks = 0;
  wire [7:0] rdat, rxd;
  wire txr, rxv, so, soe, mo, moe, io, ioe, fs, fm, fi, fn;
  wire sck_w = soe ? so : fs;
  wire mosi_w = moe ? mo : fm;
  wire miso_w = ioe ? io : fi;
  // longer bit so the far slave's reply settles through the pin synchroniser
  scs_config_status #(.HALF_BIT(4)) dut (.clock_in(clk), .rst_in(rst), .sfr_addr_in(adr),
    .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_wdata_in(wd), .sfr_rdata_out(rdat),
    .interface_enable_in(en), .tx_valid_in(txv), .tx_data_in(txd), .tx_ready_out(txr),
    .rx_valid_out(rxv), .rx_data_out(rxd), .rx_ready_in(rxr), .slave_select_in(fn),
    .sck_in(sck_w), .mosi_in(mosi_w), .miso_in(miso_w), .sck_out(so), .sck_oe_out(soe),
    .mosi_out(mo), .mosi_oe_out(moe), .miso_out(io), .miso_oe_out(ioe));
  scs_far_end far (.sck_l_in(sck_w), .mosi_l_in(mosi_w), .miso_l_in(miso_w),
    .sck_out(fs), .mosi_out(fm), .miso_out(fi), .nss_out(fn));
  initial forever #20 clk = ~clk;
  function automatic [7:0] nx(input [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task rreg(input [7:0] a);
    @(posedge clk);
    adr <= a;
    rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    #1 d = rdat;
  endtask
  task wreg(input [7:0] a, input [7:0] v);
    @(posedge clk);
    adr <= a;
    wd <= v;
    wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
  endtask
  task send(input [7:0] v); // buffer is free here, so the first edge takes it
    @(posedge clk);
    txd <= v;
    txv <= 1'b1;
    @(posedge clk) txv <= 1'b0;
  endtask
  task wait_rx;
    for (int n = 0; n < 200 && rxv !== 1'b1; n++) cyc(1);
  endtask
  task take_rx;
    @(posedge clk) rxr <= 1'b1;
    @(posedge clk) rxr <= 1'b0;
    cyc(2);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    print_verdict;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    cyc(2);
    rreg(8'ha1);
    `CHK("reset value", 8'h07, d)
    wreg(8'h33, 8'hff);
    rreg(8'h33);
    `CHK("unmapped read", 8'h00, d)
    rreg(8'ha1);
    `CHK("unmapped write", 8'h07, d)
    $display("reset and decode done");
    for (int i = 0; i < 8; i++) begin
      lf = nx(lf);
      t = {lf[7], i[2:0], lf[3:0]};
      wreg(8'ha1, t);
      rreg(8'ha1);
      `CHK("mode bits", {1'b0, t[6:4], 4'h7}, d)
      cyc(4);
      `CHK("clock idle", t[4], so)
    end
    $display("mode bits done");
    wreg(8'ha1, 8'h00);
    en <= 1'b1;
    lf = nx(lf);
    t = lf;
    send(t);
    #1;
    `CHK("tx held", 1'b0, txr)
    cyc(3);
    `CHK("tx free", 1'b1, txr)
    rreg(8'ha1);
    `CHK("byte loaded", 8'h05, d)
    lf = nx(lf);
    m = lf;
    fork
      far.xfer(m);
      begin
        #1200;
        rreg(8'ha1);
        `CHK("slave busy", 8'h89, d)
      end
    join
    wait_rx;
    `CHK("slave rx", m, rxd)
    `CHK("slave tx", t, far.cap)
    cyc(6);
    rreg(8'ha1);
    `CHK("rx pending", 8'h06, d)
    take_rx;
    rreg(8'ha1);
    `CHK("rx taken", 8'h07, d)
    $display("slave transfer done");
    en <= 1'b0;
    wreg(8'ha1, 8'h40);
    en <= 1'b1;
    lf = nx(lf);
    t = lf;
    lf = nx(lf);
    m = lf;
    far.arm(m, 1'b0);
    send(t);
    cyc(20);
    rreg(8'ha1);
    `CHK("master busy", 8'hc7, d)
    wait_rx;
    `CHK("master rx", m, rxd)
    `CHK("master tx", t, far.cap)
    take_rx;
    $display("master transfer done");
    en <= 1'b0;
    wreg(8'ha1, 8'h70);
    cyc(1);
    en <= 1'b1;
    lf = nx(lf);
    t = lf;
    lf = nx(lf);
    m = lf;
    far.arm(m, 1'b1);
    send(t);
    wait_rx;
    `CHK("mode3 rx", m, rxd)
    `CHK("mode3 tx", t, far.cap)
    take_rx;
    $display("mode three transfer done");
    print_verdict;
  end
endmodule // tb
bind scs_config_status scs_checker chk (.clock_in(clock_in), .rst_in(rst_in),
  .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
  .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
  .interface_enable_in(interface_enable_in), .rx_valid_out(rx_valid_out),
  .rx_ready_in(rx_ready_in), .slave_select_in(slave_select_in), .sck_out(sck_out),
  .sck_oe_out(sck_oe_out));
`default_nettype wire
